// *** design/cbd_top.sv ***
`timescale 1ns/1ps
`include "cbd_defines.svh"

// Operation
// - calibration trigger register is 16 bits; flags in 3..0, rest zero, resets zero
// - fast data D11.4 sets calib_flag3: charge injection, external trigger
// - fast data D11.3 sets calib_flag2: LED light, external trigger
// - fast data D11.2 sets calib_flag1: charge injection, internal trigger
// - fast data D11.1 sets calib_flag0: LED light calibration run
// - executed flag clears itself and enters ACTIVE; a zero flag does nothing
// - trigger register unreadable by link; its state shown in general status
// - type 0x0002: data 0 power off, 1 power on, 2 automatic control
// - type 0x0004: resets device, slabs, all, slow-control; 0x1000 reads back
// - type 0x0006: data 1 SLEEP, 2 READY; 0x1000 reads mode register
// - type 0x0008: one-hot power pulsing enables, 0x0020 all; no state change
// - type 0x000A: controller sends vectors, device stores; 0x1000 returns one
// - type 0x000C: one-hot slab in bits 3..0, bit 8 picks set 1
// - non-idle operation runs uninterrupted except resets, then returns to IDLE
// - automatic power bit clears when slab power goes zero; needs slab power
module cbd_top #(
	parameter int FIFO_DEPTH   = 16,
	parameter int SC_DEPTH     = 16,
	parameter int OP_CYCLES    = `CBD_OP_CYCLES,
	parameter int CALIB_CYCLES = `CBD_CALIB_CYCLES
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// link pins
	input  wire logic               lnk_clk,
	input  wire logic               lnk_fast_vld,
	input  wire logic [7:0]         lnk_comma,
	input  wire logic [7:0]         lnk_dchar,
	input  wire logic               lnk_blk_vld,
	input  wire logic [15:0]        lnk_blk_type,
	input  wire logic [15:0]        lnk_blk_data,
	output logic                    lnk_blk_rdy,
	// device state
	output cbd_pkg::cbd_state_t     dev_state,
	output logic [15:0]             gen_status,
	output logic [3:0]              calib_run,
	// power, reset and mode controls
	output logic                    pwr_slab,
	output logic                    pwr_auto,
	output logic [3:0]              rst_pulse,
	output cbd_pkg::cbd_mode_t      det_mode,
	output logic [4:0]              pp_en,
	// slab load
	output logic [3:0]              slab_sel,
	output logic                    slab_set,
	output logic                    slab_load,
	// readback answers
	output logic                    rsp_vld,
	output logic [15:0]             rsp_data
);
	import cbd_pkg::*;

	localparam int SAW = $clog2(SC_DEPTH);
	localparam int PW  = 50;

	cbd_fifo_if #(.W(32)) fif ();

	logic            lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
	logic [PW-1:0]   pin_s1_ff, pin_s2_ff;
	logic            lnk_rise;
	logic            fast_vld_s, blk_vld_s;
	logic [7:0]      comma_s, dchar_s;
	logic [15:0]     type_s, data_s;
	logic            push_ff;
	logic [31:0]     push_data_ff;
	logic            rdy_ff;
	logic [15:0]     calib_ff, nxt_calib_ff;
	logic [3:0]      calib_set, calib_clr, calib_pick;
	logic            calib_go;
	cbd_state_t      state_ff;
	logic [15:0]     timer_ff;
	logic [15:0]     hd_type, hd_data;
	logic            is_rst, take;
	logic            c_pwr, c_rst, c_mode, c_pp, c_up, c_slab, c_read;
	logic            pwr_slab_ff, pwr_auto_ff;
	logic [3:0]      rst_pulse_ff, rst_reg_ff;
	cbd_mode_t       mode_ff;
	logic [4:0]      pp_ff;
	logic [15:0]     sc_mem_ff [SC_DEPTH];
	logic [SAW-1:0]  sc_wr_ff, sc_rd_ff;
	logic [3:0]      slab_sel_ff;
	logic            slab_set_ff, slab_load_ff;
	logic [3:0]      run_ff;
	logic            rsp_vld_ff;
	logic [15:0]     rsp_data_ff;
	logic [15:0]     status_ff;

	// link pins are sampled twice before use
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lclk_s1_ff <= 1'b0;
			lclk_s2_ff <= 1'b0;
			lclk_s3_ff <= 1'b0;
			pin_s1_ff  <= '0;
			pin_s2_ff  <= '0;
		end
		else
		begin
			lclk_s1_ff <= lnk_clk;
			lclk_s2_ff <= lclk_s1_ff;
			lclk_s3_ff <= lclk_s2_ff;
			pin_s1_ff  <= {lnk_fast_vld, lnk_comma, lnk_dchar, lnk_blk_vld,
				lnk_blk_type, lnk_blk_data};
			pin_s2_ff  <= pin_s1_ff;
		end
	end

	assign lnk_rise = lclk_s2_ff & ~lclk_s3_ff;
	assign {fast_vld_s, comma_s, dchar_s, blk_vld_s, type_s, data_s} = pin_s2_ff;

	// fast command decode into the calibration trigger flags
	always_comb
	begin
		calib_set = 4'h0;
		if (lnk_rise && fast_vld_s && comma_s == `CBD_K28_3)
		begin
			case (dchar_s)
				`CBD_D11_4: calib_set = 4'h8;
				`CBD_D11_3: calib_set = 4'h4;
				`CBD_D11_2: calib_set = 4'h2;
				`CBD_D11_1: calib_set = 4'h1;
				default:    calib_set = 4'h0;
			endcase
		end
	end

	// only a set flag starts a run; lowest pending flag goes first
	assign calib_pick = calib_ff[3:0] & (~calib_ff[3:0] + 4'h1);
	assign calib_go   = (state_ff == CBD_IDLE) && (calib_ff[3:0] != 4'h0) && !take;
	assign calib_clr  = calib_go ? calib_pick : 4'h0;

	// a new setting wins over a clear in the same cycle
	always_comb
	begin
		nxt_calib_ff                                = `CBD_CALIB_RESET;
		nxt_calib_ff[`CBD_CALIB_MSB:`CBD_CALIB_LSB] = (calib_ff[3:0] & ~calib_clr)
			| calib_set;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			calib_ff <= `CBD_CALIB_RESET;
		else
			calib_ff <= nxt_calib_ff;
	end

	// block commands are queued; a full queue drops lnk_blk_rdy
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			push_ff      <= 1'b0;
			push_data_ff <= 32'h0000_0000;
			rdy_ff       <= 1'b0;
		end
		else
		begin
			push_ff      <= lnk_rise & blk_vld_s;
			push_data_ff <= {type_s, data_s};
			rdy_ff       <= fif.wr_ready;
		end
	end

	assign fif.wr_valid = push_ff;
	assign fif.wr_data  = push_data_ff;

	cbd_fifo #(
		.W (32),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk   (clk),
		.rst_n (rst_n),
		.f     (fif)
	);

	// dispatch: a busy device only accepts resets
	assign hd_type    = fif.rd_data[31:16];
	assign hd_data    = fif.rd_data[15:0];
	assign is_rst     = (hd_type == `CBD_T_RESET);
	assign take       = fif.rd_valid && (((state_ff == CBD_IDLE) && (calib_ff[3:0] == 4'h0))
		|| is_rst);
	assign fif.rd_ready = take;

	always_comb
	begin
		c_pwr  = 1'b0;
		c_rst  = 1'b0;
		c_mode = 1'b0;
		c_pp   = 1'b0;
		c_up   = 1'b0;
		c_slab = 1'b0;
		c_read = 1'b0;
		if (take)
		begin
			case (hd_type)
				`CBD_T_POWER:
					if (hd_data == `CBD_D_READ)
						c_read = 1'b1;
					else
						c_pwr = (hd_data == `CBD_PWR_OFF) || (hd_data == `CBD_PWR_ON)
							|| (hd_data == `CBD_PWR_AUTO);
				`CBD_T_RESET:
					if (hd_data == `CBD_D_READ)
						c_read = 1'b1;
					else
						c_rst = (hd_data == `CBD_RST_DEV) || (hd_data == `CBD_RST_SLAB)
							|| (hd_data == `CBD_RST_ALL) || (hd_data == `CBD_RST_SC);
				`CBD_T_MODE:
					if (hd_data == `CBD_D_READ)
						c_read = 1'b1;
					else
						c_mode = (hd_data == `CBD_MODE_SLEEP)
							|| (hd_data == `CBD_MODE_READY);
				`CBD_T_PULSE:
					if (hd_data == `CBD_D_READ)
						c_read = 1'b1;
					else
						c_pp = (hd_data == `CBD_PP_ALL) || ($onehot(hd_data)
							&& ((hd_data & ~`CBD_PP_MASK) == 16'h0000));
				`CBD_T_UPLOAD:
					if (hd_data == `CBD_D_READ)
						c_read = 1'b1;
					else
						c_up = 1'b1;
				`CBD_T_SLAB:
					c_slab = $onehot(hd_data & `CBD_SLAB_SEL_MASK)
						&& ((hd_data & ~`CBD_SLAB_LEGAL) == 16'h0000);
				default: c_read = 1'b0;
			endcase
		end
	end

	// device state and operation timer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_ff <= CBD_IDLE;
			timer_ff <= 16'h0000;
		end
		else if (c_rst)
		begin
			state_ff <= CBD_RESET;
			timer_ff <= 16'(OP_CYCLES - 1);
		end
		else if (c_pwr || c_mode || c_up || c_slab)
		begin
			if (c_pwr)
				state_ff <= CBD_POWER;
			else if (c_mode)
				state_ff <= CBD_MODE;
			else if (c_up)
				state_ff <= CBD_UPLOAD;
			else
				state_ff <= CBD_SLAB;
			timer_ff <= 16'(OP_CYCLES - 1);
		end
		else if (calib_go)
		begin
			state_ff <= CBD_ACTIVE;
			timer_ff <= 16'(CALIB_CYCLES - 1);
		end
		else if (state_ff != CBD_IDLE)
		begin
			if (timer_ff == 16'h0000)
				state_ff <= CBD_IDLE;
			else
				timer_ff <= timer_ff - 16'h0001;
		end
	end

	// calibration run indication
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			run_ff <= 4'h0;
		else if (calib_go)
			run_ff <= calib_pick;
		else if (c_rst || (state_ff == CBD_ACTIVE && timer_ff == 16'h0000))
			run_ff <= 4'h0;
	end

	// power register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pwr_slab_ff <= 1'b0;
			pwr_auto_ff <= 1'b0;
		end
		else if (c_pwr)
		begin
			case (hd_data)
				`CBD_PWR_OFF:
				begin
					pwr_slab_ff <= 1'b0;
					pwr_auto_ff <= 1'b0;
				end
				`CBD_PWR_ON:   pwr_slab_ff <= 1'b1;
				`CBD_PWR_AUTO: pwr_auto_ff <= pwr_slab_ff;
				default:       pwr_slab_ff <= pwr_slab_ff;
			endcase
		end
	end

	// reset strobes and reset register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rst_pulse_ff <= 4'h0;
			rst_reg_ff   <= 4'h0;
		end
		else
		begin
			rst_pulse_ff <= c_rst ? hd_data[3:0] : 4'h0;
			if (c_rst)
				rst_reg_ff <= hd_data[3:0];
		end
	end

	// detector mode and power pulsing
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mode_ff <= CBD_MODE_NONE;
			pp_ff   <= 5'h00;
		end
		else if (c_rst && (hd_data == `CBD_RST_DEV || hd_data == `CBD_RST_ALL))
		begin
			mode_ff <= CBD_MODE_NONE;
			pp_ff   <= 5'h00;
		end
		else
		begin
			if (c_mode)
				mode_ff <= (hd_data == `CBD_MODE_SLEEP) ? CBD_MODE_SLEEP
					: CBD_MODE_READY;
			if (c_pp)
				pp_ff <= (hd_data == `CBD_PP_ALL) ? 5'h1f : (pp_ff | hd_data[4:0]);
		end
	end

	// slow-control vector store
	always_ff @(posedge clk)
	begin
		if (c_up)
			sc_mem_ff[sc_wr_ff] <= hd_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sc_wr_ff <= '0;
			sc_rd_ff <= '0;
		end
		else if (c_rst && (hd_data == `CBD_RST_SC || hd_data == `CBD_RST_ALL))
		begin
			sc_wr_ff <= '0;
			sc_rd_ff <= '0;
		end
		else
		begin
			if (c_up)
				sc_wr_ff <= (sc_wr_ff == SAW'(SC_DEPTH - 1)) ? '0 : sc_wr_ff + 1'b1;
			if (c_read && hd_type == `CBD_T_UPLOAD)
				sc_rd_ff <= (sc_rd_ff == SAW'(SC_DEPTH - 1)) ? '0 : sc_rd_ff + 1'b1;
		end
	end

	// slab load request
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			slab_sel_ff  <= 4'h0;
			slab_set_ff  <= 1'b0;
			slab_load_ff <= 1'b0;
		end
		else
		begin
			slab_load_ff <= c_slab;
			if (c_slab)
			begin
				slab_sel_ff <= hd_data[3:0];
				slab_set_ff <= hd_data[`CBD_SLAB_SET_BIT];
			end
		end
	end

	// readback answers; the trigger register has none
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rsp_vld_ff  <= 1'b0;
			rsp_data_ff <= 16'h0000;
		end
		else
		begin
			rsp_vld_ff <= c_read;
			if (c_read)
			begin
				case (hd_type)
					`CBD_T_POWER: rsp_data_ff <= {14'h0000, pwr_auto_ff, pwr_slab_ff};
					`CBD_T_RESET: rsp_data_ff <= {12'h000, rst_reg_ff};
					`CBD_T_MODE:  rsp_data_ff <= {14'h0000, mode_ff};
					`CBD_T_PULSE: rsp_data_ff <= {11'h000, pp_ff};
					`CBD_T_UPLOAD: rsp_data_ff <= sc_mem_ff[sc_rd_ff];
					default:      rsp_data_ff <= 16'h0000;
				endcase
			end
		end
	end

	// general status: pending flags, running calibration, state
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			status_ff <= 16'h0000;
		else
			status_ff <= {5'h00, state_ff, run_ff, calib_ff[3:0]};
	end

	assign lnk_blk_rdy = rdy_ff;
	assign dev_state   = state_ff;
	assign gen_status  = status_ff;
	assign calib_run   = run_ff;
	assign pwr_slab    = pwr_slab_ff;
	assign pwr_auto    = pwr_auto_ff;
	assign rst_pulse   = rst_pulse_ff;
	assign det_mode    = mode_ff;
	assign pp_en       = pp_ff;
	assign slab_sel    = slab_sel_ff;
	assign slab_set    = slab_set_ff;
	assign slab_load   = slab_load_ff;
	assign rsp_vld     = rsp_vld_ff;
	assign rsp_data    = rsp_data_ff;
endmodule

// *** inc/cbd_defines.svh ***
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH

// fast command characters
`define CBD_K28_3          8'h7c
`define CBD_D11_1          8'h2b
`define CBD_D11_2          8'h4b
`define CBD_D11_3          8'h6b
`define CBD_D11_4          8'h8b

// calibration trigger register
`define CBD_CALIB_RESET    16'h0000
`define CBD_CALIB_LSB      0
`define CBD_CALIB_MSB      3

// block command type codes
`define CBD_T_POWER        16'h0002
`define CBD_T_RESET        16'h0004
`define CBD_T_MODE         16'h0006
`define CBD_T_PULSE        16'h0008
`define CBD_T_UPLOAD       16'h000a
`define CBD_T_SLAB         16'h000c

// block command data words
`define CBD_D_READ         16'h1000
`define CBD_PWR_OFF        16'h0000
`define CBD_PWR_ON         16'h0001
`define CBD_PWR_AUTO       16'h0002
`define CBD_RST_DEV        16'h0001
`define CBD_RST_SLAB       16'h0002
`define CBD_RST_ALL        16'h0004
`define CBD_RST_SC         16'h0008
`define CBD_MODE_SLEEP     16'h0001
`define CBD_MODE_READY     16'h0002
`define CBD_PP_ALL         16'h0020
`define CBD_PP_MASK        16'h001f
`define CBD_SLAB_SEL_MASK  16'h000f
`define CBD_SLAB_LEGAL     16'h010f
`define CBD_SLAB_SET_BIT   8

// power register fields
`define CBD_PWR_SLAB_BIT   0
`define CBD_PWR_AUTO_BIT   1

// timing
`define CBD_CLK_PERIOD_NS  10
`define CBD_OP_TIME_NS     40
`define CBD_CALIB_TIME_NS  640
`define CBD_OP_CYCLES      ((`CBD_OP_TIME_NS + `CBD_CLK_PERIOD_NS - 1) / `CBD_CLK_PERIOD_NS)
`define CBD_CALIB_CYCLES   ((`CBD_CALIB_TIME_NS + `CBD_CLK_PERIOD_NS - 1) / `CBD_CLK_PERIOD_NS)

`endif

// *** inc/cbd_pkg.sv ***
package cbd_pkg;

	typedef enum logic [2:0]
	{
		CBD_IDLE   = 3'b000,
		CBD_ACTIVE = 3'b001,
		CBD_POWER  = 3'b010,
		CBD_RESET  = 3'b011,
		CBD_MODE   = 3'b100,
		CBD_UPLOAD = 3'b101,
		CBD_SLAB   = 3'b110
	} cbd_state_t;

	typedef enum logic [1:0]
	{
		CBD_MODE_NONE  = 2'b00,
		CBD_MODE_SLEEP = 2'b01,
		CBD_MODE_READY = 2'b10
	} cbd_mode_t;

endpackage

// *** inc/cbd_fifo_if.sv ***
`timescale 1ns/1ps
interface cbd_fifo_if #(parameter int W = 32);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;

	modport fifo (input wr_valid, input wr_data, output wr_ready,
		output rd_valid, output rd_data, input rd_ready);
	modport user (output wr_valid, output wr_data, input wr_ready,
		input rd_valid, input rd_data, output rd_ready);
endinterface

// *** design/cbd_fifo.sv ***
`timescale 1ns/1ps
module cbd_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// both sides
	cbd_fifo_if.fifo f
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0]   cnt_ff;
	logic          push;
	logic          pop;

	assign f.wr_ready = (cnt_ff != (AW+1)'(D));
	assign f.rd_valid = (cnt_ff != '0);
	assign f.rd_data  = mem_ff[rd_ptr_ff];
	assign push       = f.wr_valid & f.wr_ready;
	assign pop        = f.rd_ready & f.rd_valid;

	always_ff @(posedge clk)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= f.wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff    <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(D - 1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(D - 1)) ? '0 : rd_ptr_ff + 1'b1;
			if (push && !pop)
				cnt_ff <= cnt_ff + 1'b1;
			else if (pop && !push)
				cnt_ff <= cnt_ff - 1'b1;
		end
	end
endmodule

// *** bench/cbd_lnk_model.sv ***
`timescale 1ns/1ps
module cbd_lnk_model (
	// system clock, used only to launch frames just after an edge
	input  wire logic        clk,
	// link pins
	output logic             lnk_clk,
	output logic             lnk_fast_vld,
	output logic [7:0]       lnk_comma,
	output logic [7:0]       lnk_dchar,
	output logic             lnk_blk_vld,
	output logic [15:0]      lnk_blk_type,
	output logic [15:0]      lnk_blk_data,
	input  wire logic        lnk_blk_rdy
);
	initial
	begin
		lnk_clk = 1'b0;
		lnk_fast_vld = 1'b0;
		lnk_blk_vld = 1'b0;
		lnk_comma = 8'h00;
		lnk_dchar = 8'h00;
		lnk_blk_type = 16'h0000;
		lnk_blk_data = 16'h0000;
	end

	// one frame, link clock runs only inside it; block frames wait for queue room
	task automatic frame(input logic f, input logic [15:0] a, input logic [15:0] b,
		input int idle);
		repeat (idle) @(posedge clk);
		do
			@(posedge clk);
		while (!f && lnk_blk_rdy !== 1'b1);
		lnk_fast_vld <= f;
		lnk_blk_vld <= !f;
		lnk_comma <= a[7:0];
		lnk_dchar <= b[7:0];
		lnk_blk_type <= a;
		lnk_blk_data <= b;
		#43 lnk_clk = 1'b1;
		#80 lnk_clk = 1'b0;
		// end on a settled clock edge so the next frame cannot share this time step
		#30;
		@(posedge clk);
		// released data lines show the inverse of the last value; both valid lines go low
		lnk_fast_vld <= 1'b0;
		lnk_blk_vld <= 1'b0;
		lnk_comma <= ~a[7:0];
		lnk_dchar <= ~b[7:0];
		lnk_blk_type <= ~a;
		lnk_blk_data <= ~b;
	endtask
endmodule

// *** bench/cbd_top_assertions.sv ***
`timescale 1ns/1ps
module cbd_top_chk
	import cbd_pkg::*;
#(
	parameter int OP_CYCLES    = 4,
	parameter int CALIB_CYCLES = 64
) (
	// clock and reset
	input wire logic         clk,
	input wire logic         rst_n,
	// watched outputs
	input wire cbd_state_t   dev_state,
	input wire logic [15:0]  gen_status,
	input wire logic [3:0]   calib_run,
	input wire logic         pwr_slab,
	input wire logic         pwr_auto,
	input wire logic [3:0]   rst_pulse,
	input wire logic         slab_load
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// counts cycles spent in ACTIVE
	logic [15:0] act_cnt_ff;
	always_ff @(posedge clk)
	begin
		if (!rst_n || dev_state != CBD_ACTIVE)
			act_cnt_ff <= 16'h0;
		else
			act_cnt_ff <= act_cnt_ff + 16'h1;
	end

	AST_GEN_RSVD: assert property (gen_status[15:11] == 5'h0)
		else $error("status reserved bits set");
	AST_GEN_RUN: assert property (gen_status[7:4] == $past(calib_run))
		else $error("status run bits differ");
	AST_GEN_STATE: assert property (gen_status[10:8] == $past(dev_state))
		else $error("status state bits differ");
	AST_CALIB_ONEHOT: assert property (calib_run != 4'h0 |->
		$onehot(calib_run) && dev_state == CBD_ACTIVE)
		else $error("calibration run not one-hot in ACTIVE");
	AST_CALIB_LEN: assert property ($fell(dev_state == CBD_ACTIVE) |->
		act_cnt_ff == 16'(CALIB_CYCLES) && dev_state == CBD_IDLE)
		else $error("calibration run length wrong");
	AST_RST_PULSE: assert property (rst_pulse != 4'h0 |->
		dev_state == CBD_RESET ##1 rst_pulse == 4'h0)
		else $error("reset pulse wrong");
	AST_SLAB_PULSE: assert property ($rose(dev_state == CBD_SLAB) |->
		slab_load ##1 !slab_load)
		else $error("slab load pulse wrong");
	AST_MODE_LEN: assert property ($rose(dev_state == CBD_MODE) |->
		(dev_state == CBD_MODE)[*4] ##1 dev_state == CBD_IDLE)
		else $error("mode operation length wrong");
	AST_AUTO_SLAB: assert property (pwr_auto |-> pwr_slab)
		else $error("automatic power without slab power");
endmodule

bind cbd_top cbd_top_chk #(.OP_CYCLES(OP_CYCLES), .CALIB_CYCLES(CALIB_CYCLES))
	cbd_top_chk_inst (.clk(clk), .rst_n(rst_n), .dev_state(dev_state),
	.gen_status(gen_status), .calib_run(calib_run), .pwr_slab(pwr_slab),
	.pwr_auto(pwr_auto), .rst_pulse(rst_pulse), .slab_load(slab_load));

// *** bench/cbd_top_tb.sv ***
`timescale 1ns/1ps
`include "cbd_defines.svh"
module cbd_top_tb;
	import cbd_pkg::*;
	logic clk, rst_n, lnk_clk, lnk_fast_vld, lnk_blk_vld, lnk_blk_rdy;
	logic [7:0] lnk_comma, lnk_dchar;
	logic [15:0] lnk_blk_type, lnk_blk_data, gen_status, rsp_data, d;
	logic [15:0] rsp_q[$];
	logic [15:0] vec[16];
	cbd_state_t dev_state;
	cbd_mode_t det_mode;
	logic [3:0] calib_run, rst_pulse, slab_sel, last_rst;
	logic [4:0] pp_en, last_slab, exp_pp;
	logic pwr_slab, pwr_auto, slab_set, slab_load, rsp_vld;
	int mismatches = 0, n_compared = 0, n_slab = 0, k;

	cbd_top #(.CALIB_CYCLES(320)) cbd_top_inst (.clk(clk), .rst_n(rst_n),
		.lnk_clk(lnk_clk), .lnk_fast_vld(lnk_fast_vld), .lnk_comma(lnk_comma),
		.lnk_dchar(lnk_dchar), .lnk_blk_vld(lnk_blk_vld), .lnk_blk_type(lnk_blk_type),
		.lnk_blk_data(lnk_blk_data), .lnk_blk_rdy(lnk_blk_rdy), .dev_state(dev_state),
		.gen_status(gen_status), .calib_run(calib_run), .pwr_slab(pwr_slab),
		.pwr_auto(pwr_auto), .rst_pulse(rst_pulse), .det_mode(det_mode), .pp_en(pp_en),
		.slab_sel(slab_sel), .slab_set(slab_set), .slab_load(slab_load),
		.rsp_vld(rsp_vld), .rsp_data(rsp_data));
	cbd_lnk_model cbd_lnk_model_inst (.clk(clk), .lnk_clk(lnk_clk),
		.lnk_fast_vld(lnk_fast_vld), .lnk_comma(lnk_comma), .lnk_dchar(lnk_dchar),
		.lnk_blk_vld(lnk_blk_vld), .lnk_blk_type(lnk_blk_type),
		.lnk_blk_data(lnk_blk_data), .lnk_blk_rdy(lnk_blk_rdy));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// collect answers and one-clock pulses
	always @(posedge clk)
	begin
		if (rsp_vld === 1'b1)
			rsp_q.push_back(rsp_data);
		if (rst_pulse !== 4'h0)
			last_rst <= rst_pulse;
		if (slab_load === 1'b1)
		begin
			last_slab <= {slab_set, slab_sel};
			n_slab++;
		end
	end

	function automatic logic [3:0] calib_exp(input logic [7:0] ch);
		calib_exp = 4'h1 << ((ch - 8'h2b) >> 5);
	endfunction
	function automatic logic [4:0] pp_exp(input logic [4:0] cur, input logic [15:0] v);
		pp_exp = (v == `CBD_PP_ALL) ? 5'h1f : cur | v[4:0];
	endfunction
	function automatic logic [15:0] pop();
		pop = 16'hxxxx;
		if (rsp_q.size() != 0)
			pop = rsp_q.pop_front();
	endfunction

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic blk(input logic [15:0] t, input logic [15:0] v);
		cbd_lnk_model_inst.frame(1'b0, t, v, $urandom % 3);
	endtask
	task automatic fast(input logic [7:0] c, input logic [7:0] ch);
		cbd_lnk_model_inst.frame(1'b1, {8'h00, c}, {8'h00, ch}, 0);
	endtask
	task automatic stop_test();
		if (mismatches == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#300000;
		mismatches++;
		stop_test();
	end

	initial
	begin
		rst_n = 1'b0;
		void'($urandom(20));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("state", 16'(CBD_IDLE), 16'(dev_state));
		chk("status", 16'h0, gen_status);
		foreach (vec[i])
		begin
			if (i < 4)
			begin
				d = 16'h2b + 16'(i * 32);
				fast(`CBD_K28_3, d[7:0]);
				chk("run", 16'(calib_exp(d[7:0])), 16'(calib_run));
				chk("active", 16'(CBD_ACTIVE), 16'(dev_state));
				for (k = 0; k < 400 && dev_state !== CBD_IDLE; k++) @(posedge clk);
				chk("run_clear", 16'h0, 16'(calib_run));
			end
		end
		fast(8'hbc, `CBD_D11_1);
		chk("bad_comma", 16'h0, 16'(calib_run));
		blk(`CBD_T_POWER, `CBD_PWR_AUTO);
		chk("auto_no_slab", 16'h0, 16'(pwr_auto));
		blk(`CBD_T_POWER, `CBD_PWR_ON);
		chk("slab_pwr", 16'h1, 16'(pwr_slab));
		blk(`CBD_T_POWER, `CBD_PWR_AUTO);
		chk("auto", 16'h1, 16'(pwr_auto));
		blk(`CBD_T_POWER, `CBD_D_READ);
		chk("pwr_read", 16'h3, pop());
		blk(`CBD_T_POWER, `CBD_PWR_OFF);
		chk("pwr_off", 16'h0, {14'h0, pwr_auto, pwr_slab});
		blk(`CBD_T_MODE, `CBD_MODE_SLEEP);
		chk("sleep", 16'(CBD_MODE_SLEEP), 16'(det_mode));
		blk(`CBD_T_MODE, `CBD_MODE_READY);
		blk(`CBD_T_MODE, 16'h0003);
		chk("ready", 16'(CBD_MODE_READY), 16'(det_mode));
		blk(`CBD_T_MODE, `CBD_D_READ);
		chk("mode_read", 16'h2, pop());
		blk(16'h0020, 16'h0001);
		chk("unknown", 16'(CBD_IDLE), 16'(dev_state) | 16'(rsp_q.size()));
		exp_pp = 5'h0;
		repeat (5)
		begin
			d = 16'h1 << ($urandom % 5);
			blk(`CBD_T_PULSE, d);
			exp_pp = pp_exp(exp_pp, d);
			chk("pulsing", 16'(exp_pp), 16'(pp_en));
		end
		blk(`CBD_T_PULSE, `CBD_PP_ALL);
		chk("pulse_all", 16'(pp_exp(exp_pp, `CBD_PP_ALL)), 16'(pp_en));
		blk(`CBD_T_PULSE, `CBD_D_READ);
		chk("pp_read", 16'h001f, pop());
		for (int i = 0; i < 4; i++)
		begin
			blk(`CBD_T_RESET, 16'h1 << i);
			chk("rst", 16'h1 << i, 16'(last_rst));
		end
		blk(`CBD_T_RESET, `CBD_D_READ);
		chk("rst_read", 16'h8, pop());
		chk("rst_clear", 16'h0, {9'h0, pp_en, det_mode});
		for (int i = 0; i < 8; i++)
		begin
			d = ((i % 2) ? 16'h0100 : 16'h0) | (16'h1 << (i / 2));
			blk(`CBD_T_SLAB, d);
			chk("slab", {11'h0, d[8], d[3:0]}, 16'(last_slab));
		end
		k = n_slab;
		blk(`CBD_T_SLAB, 16'h0003);
		chk("slab_bad", 16'(k), 16'(n_slab));
		// queue fills while a calibration run holds dispatch
		fast(`CBD_K28_3, `CBD_D11_1);
		foreach (vec[i])
		begin
			vec[i] = 16'($urandom) & 16'h0fff;
			cbd_lnk_model_inst.frame(1'b0, `CBD_T_UPLOAD, vec[i], 0);
		end
		repeat (2) @(posedge clk);
		chk("queue_full", 16'h0, 16'(lnk_blk_rdy));
		repeat (3) blk(`CBD_T_UPLOAD, `CBD_D_READ);
		for (k = 0; k < 600 && rsp_q.size() < 3; k++) @(posedge clk);
		for (int i = 0; i < 3; i++)
			chk("vector", vec[i], pop());
		stop_test();
	end
endmodule
